// >>> frame_checksum.v
// Running byte sum used to form the trailing frame checksum.
`timescale 1ns/10ps
`default_nettype none

module frame_checksum (
  input wire pclk,
  input wire presetn,
  input wire clear,
  input wire add,
  input wire [7:0] data,
  output reg [7:0] sum_q
);

  // Clear wins over add, so a new frame always starts from zero.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sum_q <= 8'h00;
    end else if (clear) begin
      sum_q <= 8'h00;
    end else if (add) begin
      sum_q <= sum_q + data;
    end
  end

endmodule

`default_nettype wire

// >>> io_byte_select.v
// Picks the frame byte that belongs to a given layout slot.
`timescale 1ns/10ps
`default_nettype none
`include "io_frame_defs.vh"

module io_byte_select (
  input wire [4:0] slot,
  input wire [15:0] len,
  input wire [63:0] addr64,
  input wire [15:0] net16,
  input wire [7:0] opts,
  input wire [7:0] nsamp,
  input wire [15:0] dmask,
  input wire [7:0] amask,
  input wire [15:0] dsamp,
  input wire [63:0] an_flat,
  output reg [7:0] byte_out
);

  wire [15:0] an_word [0:3]; // Analog readings split per input.
  wire [4:0] an_rel; // Slot offset inside the analog area.
  wire [4:0] addr_rel; // Slot offset inside the long address.

  genvar g;
  // One word per analog input, input 0 in the low bits.
  generate
    for (g = 0; g < 4; g = g + 1) begin : an_split
      assign an_word[g] = an_flat[16*g+15:16*g];
    end
  endgenerate

  assign an_rel = slot - `SLOT_AN;
  assign addr_rel = slot - `SLOT_ADDR;

  // Every multi-byte field goes out high byte first.
  always @* begin
    byte_out = 8'h00;
    if (slot == `SLOT_DELIM) begin
      byte_out = `START_DELIM; // R1 R18
    end else if (slot == `SLOT_LEN_HI) begin
      byte_out = len[15:8]; // R2 R17
    end else if (slot == `SLOT_LEN_LO) begin
      byte_out = len[7:0]; // R2
    end else if (slot == `SLOT_TYPE) begin
      byte_out = `FRAME_TYPE; // R3
    end else if (slot < `SLOT_NET) begin
      byte_out = addr64[8*(7-addr_rel[2:0])+:8]; // R4 R17
    end else if (slot == `SLOT_NET) begin
      byte_out = net16[15:8]; // R5
    end else if (slot == `SLOT_OPT - 5'h01) begin
      byte_out = net16[7:0]; // R5
    end else if (slot == `SLOT_OPT) begin
      byte_out = opts; // R6
    end else if (slot == `SLOT_NSAMP) begin
      byte_out = nsamp; // R7
    end else if (slot == `SLOT_DMASK) begin
      byte_out = dmask[15:8]; // R8
    end else if (slot == `SLOT_AMASK - 5'h01) begin
      byte_out = dmask[7:0]; // R8
    end else if (slot == `SLOT_AMASK) begin
      byte_out = amask; // R9
    end else if (slot == `SLOT_DIG) begin
      byte_out = dsamp[15:8]; // R10 R11
    end else if (slot == `SLOT_AN - 5'h01) begin
      byte_out = dsamp[7:0]; // R10 R11
    end else if (slot < `SLOT_CHK) begin
      // High byte on the even offset of each pair.
      if (an_rel[0] == 1'b0) begin
        byte_out = an_word[an_rel[2:1]][15:8]; // R12
      end else begin
        byte_out = an_word[an_rel[2:1]][7:0]; // R12
      end
    end
  end

endmodule

`default_nettype wire

// >>> io_frame_defs.vh
// Constants shared by the I/O sample frame builder files.
`ifndef IO_FRAME_DEFS_VH
`define IO_FRAME_DEFS_VH

// Fixed frame bytes.
`define START_DELIM 8'h7e
`define FRAME_TYPE 8'h92
// Bytes from the frame type to the analog mask, inclusive.
`define LEN_BASE 16'h0010

// Byte slots of the full frame layout; absent fields are skipped.
`define SLOT_DELIM 5'h00
`define SLOT_LEN_HI 5'h01
`define SLOT_LEN_LO 5'h02
`define SLOT_TYPE 5'h03
`define SLOT_ADDR 5'h04
`define SLOT_NET 5'h0c
`define SLOT_OPT 5'h0e
`define SLOT_NSAMP 5'h0f
`define SLOT_DMASK 5'h10
`define SLOT_AMASK 5'h12
`define SLOT_DIG 5'h13
`define SLOT_AN 5'h15
`define SLOT_CHK 5'h1d

// Register byte addresses.
`define OFS_CTRL 8'h00
`define OFS_CMD 8'h04
`define OFS_STATUS 8'h08
`define OFS_ADDR_HI 8'h0c
`define OFS_ADDR_LO 8'h10
`define OFS_NET 8'h14
`define OFS_MASKS 8'h18
`define OFS_DSAMP 8'h1c
`define OFS_AN01 8'h20
`define OFS_AN23 8'h24

// Field positions, valid-bit masks and reset values.
`define CTRL_API_EN 0
`define CMD_SAMPLE 0
`define OPT_VALID 8'h33
`define DMASK_VALID 16'h7fff
`define AMASK_VALID 8'h8f
`define CTRL_RESET 1'b0
`define NSAMP_RESET 8'h01

`endif

// >>> io_frame_monitor.sv
// Port checker for the I/O sample frame builder.
`timescale 1ns/10ps
`default_nettype none
module io_frame_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] tx_data_q,
  input wire logic tx_valid_q,
  input wire logic tx_last_q,
  input wire logic tx_ready,
  input wire logic frame_active_q
);
  // Byte index, running sum and captured header fields.
  logic [4:0] cnt_q;
  logic [7:0] sum_q;
  logic [15:0] len_q;
  logic [7:0] dhi_q;
  logic [7:0] am_q;
  logic dnz_q;
  logic [15:0] exp_len;
  wire take = tx_valid_q && tx_ready;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Tracks each accepted byte of the frame in flight.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 5'h00;
      sum_q <= 8'h00;
    end else if (!frame_active_q) begin
      cnt_q <= 5'h00;
      sum_q <= 8'h00;
    end else if (take) begin
      cnt_q <= cnt_q + 5'h01;
      if (cnt_q >= 5'h03) sum_q <= sum_q + tx_data_q;
      if (cnt_q == 5'h01) len_q[15:8] <= tx_data_q;
      if (cnt_q == 5'h02) len_q[7:0] <= tx_data_q;
      if (cnt_q == 5'h10) dhi_q <= tx_data_q;
      if (cnt_q == 5'h11) dnz_q <= (dhi_q | tx_data_q) != 8'h00;
      if (cnt_q == 5'h12) am_q <= tx_data_q;
    end
  end
  // Length implied by the two masks.
  always_comb begin
    exp_len = 16'h0010 + (dnz_q ? 16'h0002 : 16'h0000);
    for (int i = 0; i < 4; i++) if (am_q[i]) exp_len = exp_len + 16'h0002;
  end
  sequence s_idle; !frame_active_q; endsequence
  sequence s_open; frame_active_q && tx_valid_q; endsequence
  property p_start;
    s_idle ##1 s_open |-> tx_data_q == 8'h7e && !tx_last_q;
  endproperty
  a_start: assert property (p_start)
    else $error("frame does not open with the delimiter");
  property p_type; tx_valid_q && cnt_q == 5'h03 |-> tx_data_q == 8'h92;
  endproperty
  a_type: assert property (p_type)
    else $error("wrong frame type byte");
  property p_opts; tx_valid_q && cnt_q == 5'h0e |-> !(tx_data_q & 8'hcc);
  endproperty
  a_opts: assert property (p_opts)
    else $error("reserved option bit set");
  property p_dmask; tx_valid_q && cnt_q == 5'h10 |-> !tx_data_q[7];
  endproperty
  a_dmask: assert property (p_dmask)
    else $error("digital mask bit 15 set");
  property p_amask; tx_valid_q && cnt_q == 5'h12 |-> !(tx_data_q & 8'h70);
  endproperty
  a_amask: assert property (p_amask)
    else $error("unused analog mask bit set");
  property p_len; tx_valid_q && cnt_q == 5'h13 |-> len_q == exp_len;
  endproperty
  a_len: assert property (p_len)
    else $error("length disagrees with masks");
  property p_sum;
    tx_valid_q && tx_last_q |-> tx_data_q == 8'hff - sum_q &&
      {11'h000, cnt_q} == len_q + 16'h0003;
  endproperty
  a_sum: assert property (p_sum)
    else $error("bad checksum or byte count");
  property p_hold;
    tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_data_q)
      && $stable(tx_last_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("byte changed before it was taken");
  property p_end; take && tx_last_q |=> !tx_valid_q && !frame_active_q;
  endproperty
  a_end: assert property (p_end)
    else $error("frame runs past the checksum");
endmodule
bind io_sample_frame_builder io_frame_monitor i_io_frame_monitor (
  .pclk(pclk), .presetn(presetn), .tx_data_q(tx_data_q),
  .tx_valid_q(tx_valid_q), .tx_last_q(tx_last_q), .tx_ready(tx_ready),
  .frame_active_q(frame_active_q));
`default_nettype wire

// >>> io_sample_frame_builder.v
// APB-controlled builder of the serial I/O sample report frame.
//
// Operation
// R1: Frame opens with one start delimiter byte.
// R2: Length counts bytes between length and checksum.
// R3: Frame type byte 0x92 at offset three.
// R4: Sender long address at offsets four to eleven.
// R5: Sender network address at offsets twelve, thirteen.
// R6: Options byte keeps bits 0,1,4,5 only.
// R7: Offset fifteen carries number of sample sets.
// R8: Digital mask covers lines 0-14, bit15 zero.
// R9: Analog mask bits 0-3 and bit 7.
// R10: Digital samples only when digital mask nonzero.
// R11: Digital samples zero where line not enabled.
// R12: One reading per enabled analog input.
// R13: Analog readings ascend from input 0 to 3.
// R14: Checksum is 0xFF minus sum from offset 3.
// R15: Frame sent only when api_output_option is 0.
// R16: Frames forwarded only in frame API mode.
// R17: Multi-byte fields go out high byte first.
// R18: Start delimiter value is 0x7E.
// R19: Host drops bad frames, waits for delimiter.
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "io_frame_defs.vh"

module io_sample_frame_builder (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_q,
  output reg pready_q,
  output reg pslverr_q,
  output reg [7:0] tx_data_q,
  output reg tx_valid_q,
  output reg tx_last_q,
  input wire tx_ready,
  output reg frame_active_q
);

  // Builder states. The sequencer only needs to know whether a frame
  // is on the wire; the layout slot carries the finer position.
  localparam ST_IDLE = 1'b0;
  localparam ST_SEND = 1'b1;

  // Control: frame API mode enable and the output option value.
  reg api_mode_en_q;
  reg [7:0] api_output_option_q;
  // Sample report contents, written by software per message.
  reg [63:0] addr64_q;
  reg [15:0] net16_q;
  reg [7:0] opts_q;
  reg [7:0] nsamp_q;
  reg [15:0] dmask_q;
  reg [7:0] amask_q;
  reg [15:0] dsamp_q;
  reg [63:0] an_flat_q;
  // Activity counters shown in the status register.
  reg [7:0] sent_cnt_q;
  reg [7:0] drop_cnt_q;
  // Builder state and current layout slot.
  reg state_q;
  reg [4:0] slot_q;

  // Bus decode and stream handshake terms.
  wire access_done; // APB transfer completes at this edge.
  wire wr_done; // Completing write.
  wire setup_seen; // First access cycle, answer prepared here.
  wire field_reg; // Address names a frame content register.
  wire mapped; // Address names any register.
  wire busy_refuse; // Content write refused during a frame.
  wire sample_cmd; // Software reports an arriving sample message.
  wire may_emit; // Mode and option allow a frame.
  wire tx_take; // Current byte accepted by the serial side.
  wire [7:0] sel_byte; // Byte of the slot that comes next.
  wire [7:0] sum_q; // Running sum from the frame type onward.
  wire [7:0] chk_byte; // Checksum including the byte on the port.
  wire [15:0] frame_len; // Value of the length field.
  wire [2:0] an_count; // Number of enabled analog inputs.
  reg [4:0] next_slot; // Slot that follows slot_q.
  reg [4:0] sel_slot; // Slot fed to the byte selector.
  reg [31:0] rd_mux; // Read data before registering.
  integer k;

  // APB decode. A transfer completes at the edge where the access
  // phase meets the registered ready; the setup term fires one edge
  // earlier so that the answer is prepared in time.
  assign access_done = psel & penable & pready_q;
  assign wr_done = access_done & pwrite;
  assign setup_seen = psel & penable & ~pready_q;
  // Content registers sit on word addresses from the long address up
  // to the last analog pair.
  assign field_reg = (paddr >= `OFS_ADDR_HI) && (paddr <= `OFS_AN23)
    && (paddr[1:0] == 2'b00);
  assign mapped = field_reg || (paddr == `OFS_CTRL)
    || (paddr == `OFS_CMD) || (paddr == `OFS_STATUS);
  // Content is frozen while a frame goes out, so the length and the
  // checksum always describe the bytes actually sent.
  assign busy_refuse = pwrite & field_reg & (state_q == ST_SEND);
  // A sample message is reported by writing the command bit.
  assign sample_cmd = wr_done & (paddr == `OFS_CMD)
    & pwdata[`CMD_SAMPLE];
  // Forwarding needs frame mode and the standard output option.
  assign may_emit = api_mode_en_q // R16
    & (api_output_option_q == 8'h00); // R15
  // A byte leaves when valid meets ready at a rising edge.
  assign tx_take = tx_valid_q & tx_ready;

  // Length grows by two for digital samples and two per analog input.
  // Analog bit 7 is supply voltage; it shows in the mask only and
  // adds no reading to the frame.
  assign an_count = {2'b00, amask_q[0]} + {2'b00, amask_q[1]}
    + {2'b00, amask_q[2]} + {2'b00, amask_q[3]};
  assign frame_len = `LEN_BASE // R2
    + ((dmask_q != 16'h0000) ? 16'h0002 : 16'h0000)
    + {12'h000, an_count, 1'b0};

  // Final byte: 0xFF minus the low byte of the sum.
  // The byte now on the port is the last data byte, so it is folded
  // in here before the checksum takes its place.
  assign chk_byte = 8'hff - (sum_q + tx_data_q); // R14

  // Skip the digital samples when no line is enabled, and skip
  // each analog pair whose input is off, in ascending order.
  always @* begin
    // Default: the very next slot of the layout.
    next_slot = slot_q + 5'h01;
    if ((next_slot == `SLOT_DIG) && (dmask_q == 16'h0000)) begin
      next_slot = `SLOT_AN; // R10
    end
    // Inputs are tested in ascending order, so a run of disabled
    // inputs is skipped within one cycle.
    for (k = 0; k < 4; k = k + 1) begin
      if ((next_slot == `SLOT_AN + 2 * k) && !amask_q[k]) begin
        next_slot = next_slot + 5'h02; // R12 R13
      end
    end
  end

  // The selector looks ahead: slot 0 at start, else the next slot.
  always @* begin
    if (state_q == ST_IDLE) begin
      // Idle: the delimiter waits for the next start.
      sel_slot = `SLOT_DELIM;
    end else begin
      // Sending: fetch the byte that follows the one on the port.
      sel_slot = next_slot;
    end
  end

  io_byte_select u_select (
    .slot(sel_slot),
    .len(frame_len),
    .addr64(addr64_q),
    .net16(net16_q),
    .opts(opts_q),
    .nsamp(nsamp_q),
    .dmask(dmask_q),
    .amask(amask_q),
    .dsamp(dsamp_q),
    .an_flat(an_flat_q),
    .byte_out(sel_byte)
  );

  // Sum starts at the frame type and ends before the checksum.
  // It is cleared while idle, so no stale sum reaches a new frame.
  frame_checksum u_checksum (
    .pclk(pclk),
    .presetn(presetn),
    .clear(state_q == ST_IDLE),
    .add(tx_take && (slot_q >= `SLOT_TYPE) && (slot_q != `SLOT_CHK)),
    .data(tx_data_q),
    .sum_q(sum_q)
  );

  // Read multiplexer; unmapped addresses read as zero.
  always @* begin
    rd_mux = 32'h0000_0000;
    if (paddr == `OFS_CTRL) begin
      rd_mux = {16'h0000, api_output_option_q, 7'h00, api_mode_en_q};
    end else if (paddr == `OFS_STATUS) begin
      rd_mux = {8'h00, drop_cnt_q, sent_cnt_q, 7'h00, state_q};
    end else if (paddr == `OFS_ADDR_HI) begin
      rd_mux = addr64_q[63:32];
    end else if (paddr == `OFS_ADDR_LO) begin
      rd_mux = addr64_q[31:0];
    end else if (paddr == `OFS_NET) begin
      rd_mux = {nsamp_q, opts_q, net16_q};
    end else if (paddr == `OFS_MASKS) begin
      rd_mux = {8'h00, amask_q, dmask_q};
    end else if (paddr == `OFS_DSAMP) begin
      rd_mux = {16'h0000, dsamp_q};
    end else if (paddr == `OFS_AN01) begin
      rd_mux = an_flat_q[31:0];
    end else if (paddr == `OFS_AN23) begin
      rd_mux = an_flat_q[63:32];
    end
  end

  // APB answer: one wait state, data and error prepared with ready.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup_seen) begin
      // Answer the access phase after one wait state.
      pready_q <= 1'b1;
      prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_q <= ~mapped | busy_refuse;
    end else begin
      // Ready and its data stand for one cycle only.
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
  end

  // Control register writes.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      api_mode_en_q <= `CTRL_RESET;
      api_output_option_q <= 8'h00;
    end else if (wr_done && (paddr == `OFS_CTRL)) begin
      // Any value is accepted; only these fields are kept.
      api_mode_en_q <= pwdata[`CTRL_API_EN];
      api_output_option_q <= pwdata[15:8];
    end
  end

  // Frame content writes; held still while a frame is going out.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr64_q <= 64'h0000_0000_0000_0000;
      net16_q <= 16'h0000;
      opts_q <= 8'h00;
      nsamp_q <= `NSAMP_RESET;
      dmask_q <= 16'h0000;
      amask_q <= 8'h00;
      dsamp_q <= 16'h0000;
      an_flat_q <= 64'h0000_0000_0000_0000;
    end else if (wr_done && field_reg && !pslverr_q) begin
      // A write answered with an error is never applied, even when the
      // frame ended between the setup edge and the access edge.
      if (paddr == `OFS_ADDR_HI) begin
        addr64_q[63:32] <= pwdata;
      end else if (paddr == `OFS_ADDR_LO) begin
        addr64_q[31:0] <= pwdata;
      end else if (paddr == `OFS_NET) begin
        net16_q <= pwdata[15:0];
        opts_q <= pwdata[23:16] & `OPT_VALID; // R6
        nsamp_q <= pwdata[31:24]; // R7
      end else if (paddr == `OFS_MASKS) begin
        dmask_q <= pwdata[15:0] & `DMASK_VALID; // R8
        amask_q <= pwdata[23:16] & `AMASK_VALID; // R9
        // Lines without sampling read back zero.
        dsamp_q <= dsamp_q & pwdata[15:0] & `DMASK_VALID; // R11
      end else if (paddr == `OFS_DSAMP) begin
        dsamp_q <= pwdata[15:0] & dmask_q; // R11
      end else if (paddr == `OFS_AN01) begin
        // Analog inputs 0 and 1.
        an_flat_q[31:0] <= pwdata;
      end else begin
        // Analog inputs 2 and 3.
        an_flat_q[63:32] <= pwdata;
      end
    end
  end

  // Counters: frames finished, and sample messages not forwarded.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sent_cnt_q <= 8'h00;
      drop_cnt_q <= 8'h00;
    end else begin
      // Both counters wrap; software compares successive readings.
      if (tx_take && (slot_q == `SLOT_CHK)) begin
        sent_cnt_q <= sent_cnt_q + 8'h01;
      end
      // A message met while busy or while forwarding is off is lost.
      if (sample_cmd && (!may_emit || (state_q == ST_SEND))) begin
        drop_cnt_q <= drop_cnt_q + 8'h01; // R15 R16
      end
    end
  end

  // Frame sequencer: holds each byte until the serial side takes it.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      slot_q <= `SLOT_DELIM;
      tx_data_q <= 8'h00;
      tx_valid_q <= 1'b0;
      tx_last_q <= 1'b0;
      frame_active_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // Start only on a message that forwarding allows.
          if (sample_cmd && may_emit) begin // R15 R16
            state_q <= ST_SEND;
            slot_q <= `SLOT_DELIM;
            tx_data_q <= sel_byte; // R1
            tx_valid_q <= 1'b1;
            tx_last_q <= 1'b0;
            frame_active_q <= 1'b1;
          end
        end
        ST_SEND: begin
          if (tx_take) begin
            if (slot_q == `SLOT_CHK) begin
              // Checksum taken: the frame is complete.
              state_q <= ST_IDLE;
              slot_q <= `SLOT_DELIM;
              tx_valid_q <= 1'b0;
              tx_last_q <= 1'b0;
              frame_active_q <= 1'b0;
            end else if (next_slot == `SLOT_CHK) begin
              // Next byte is the checksum; mark it as the last.
              slot_q <= next_slot;
              tx_data_q <= chk_byte; // R14
              tx_last_q <= 1'b1;
            end else begin
              // Ordinary byte: move to the next present slot.
              slot_q <= next_slot; // R13 R17
              tx_data_q <= sel_byte;
            end
          end
        end
        default: begin
          // Unreachable with one state bit; kept as a safe fallback.
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> serial_host.sv
// Host model that receives and checks frames on the serial side.
`timescale 1ns/10ps
`default_nettype none
module serial_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  input wire logic slow,
  output logic tx_ready
);
  // Bytes of the latest frame and counts of kept and dropped frames.
  logic [7:0] rx_q [$];
  int good_q = 0;
  int bad_q = 0;
  logic in_q;
  // True when checksum and byte count agree with the header.
  function automatic logic frame_ok();
    logic [7:0] s;
    s = 8'h00;
    for (int i = 3; i < rx_q.size(); i++) s += rx_q[i];
    return s == 8'hff && rx_q.size() == {rx_q[1], rx_q[2]} + 4;
  endfunction
  // Takes a byte per accepted edge; slow mode stalls every other cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      in_q <= 1'b0;
    end else begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      if (tx_valid && tx_ready) begin
        if (!in_q && tx_data == 8'h7e) begin
          rx_q = {tx_data};
          in_q <= 1'b1;
        end else if (in_q) begin
          rx_q.push_back(tx_data);
        end
        if (in_q && tx_last) begin
          in_q <= 1'b0;
          if (frame_ok()) good_q++;
          else bad_q++;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the I/O sample frame builder.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin \
  checks++; \
  if ((a) !== (b)) begin \
    miscompares++; \
    $display("BAD %0t %h %h", $time, (a), (b)); \
  end \
end
module tb;
  // Bus, stream and bench state.
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic slow = 1'b0;
  wire [31:0] prdata_q;
  wire [7:0] tx_data_q;
  wire pready_q, pslverr_q, tx_valid_q, tx_last_q, tx_ready, frame_active_q;
  logic [31:0] rd;
  logic er;
  logic [7:0] exp_q [$];
  int miscompares = 0;
  int checks = 0;
  // Clock at 40 MHz.
  always #12.5 pclk = ~pclk;
  io_sample_frame_builder i_io_sample_frame_builder (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q), .tx_data_q(tx_data_q),
    .tx_valid_q(tx_valid_q), .tx_last_q(tx_last_q), .tx_ready(tx_ready),
    .frame_active_q(frame_active_q));
  serial_host i_serial_host (
    .pclk(pclk), .presetn(presetn), .tx_data(tx_data_q),
    .tx_valid(tx_valid_q), .tx_last(tx_last_q), .slow(slow),
    .tx_ready(tx_ready));
  // Prints the verdict and ends the run.
  task automatic test_done();
    if (miscompares == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One APB transfer; read data and error land in rd and er.
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready_q !== 1'b1 && n < 16);
    if (n >= 16) begin
      miscompares++;
      test_done();
    end
    rd = prdata_q;
    er = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits, bounded, until the host has closed one more frame.
  task automatic wait_frame(input int f0);
    int n;
    n = 0;
    while (i_serial_host.good_q + i_serial_host.bad_q == f0) begin
      @(posedge pclk);
      n++;
      if (n > 400) begin
        miscompares++;
        test_done();
      end
    end
  endtask
  // Builds the expected frame from the field values.
  task automatic build(input logic [63:0] ad, input logic [15:0] nt,
      input logic [7:0] op, input logic [7:0] ns, input logic [15:0] dm,
      input logic [7:0] am, input logic [15:0] ds, input logic [63:0] an);
    logic [7:0] s;
    logic [15:0] ln;
    exp_q = {8'h92};
    for (int i = 7; i >= 0; i--) exp_q.push_back(ad[i*8+:8]);
    exp_q = {exp_q, nt[15:8], nt[7:0], op, ns, dm[15:8], dm[7:0], am};
    if (dm != 16'h0) exp_q = {exp_q, ds[15:8], ds[7:0]};
    for (int i = 0; i < 4; i++) if (am[i]) begin
      exp_q = {exp_q, an[i*16+8+:8], an[i*16+:8]};
    end
    s = 8'hff;
    foreach (exp_q[i]) s -= exp_q[i];
    ln = 16'(exp_q.size());
    exp_q = {8'h7e, ln[15:8], ln[7:0], exp_q, s};
  endtask
  // Compares the frame the host received with the expected one.
  task automatic cmp_frame();
    logic [7:0] b;
    `CHK(i_serial_host.bad_q, 0)
    `CHK(i_serial_host.rx_q.size(), exp_q.size())
    foreach (exp_q[i]) begin
      b = i_serial_host.rx_q[i];
      `CHK(b, exp_q[i])
    end
  endtask
  // Unmapped access, reset values, and sample messages that are dropped.
  task automatic t_refuse();
    apb(1'b0, 8'h40, 32'h0);
    `CHK(er, 1'b1)
    `CHK(rd, 32'h0)
    apb(1'b0, 8'h14, 32'h0);
    `CHK(rd, 32'h0100_0000)
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    `CHK(rd, 32'h0001_0000)
    apb(1'b1, 8'h00, 32'h0000_0101);
    apb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h0000_0101)
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    `CHK(rd, 32'h0002_0000)
    `CHK(i_serial_host.rx_q.size(), 0)
  endtask
  // Full frame with digital and two analog readings, slow host.
  task automatic t_sample();
    int f0;
    slow <= 1'b1;
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h0c, 32'h1122_3344);
    apb(1'b1, 8'h10, 32'h5566_7788);
    apb(1'b1, 8'h14, 32'h01ff_87ac);
    apb(1'b0, 8'h14, 32'h0);
    `CHK(rd, 32'h0133_87ac)
    apb(1'b1, 8'h18, 32'h0006_0038);
    apb(1'b1, 8'h1c, 32'h0000_002c);
    apb(1'b1, 8'h20, 32'h0225_1111);
    apb(1'b1, 8'h24, 32'h4444_00f8);
    `CHK(er, 1'b0)
    apb(1'b1, 8'h04, 32'h0);
    f0 = i_serial_host.good_q + i_serial_host.bad_q;
    apb(1'b1, 8'h04, 32'h1);
    wait_frame(f0);
    build(64'h1122_3344_5566_7788, 16'h87ac, 8'h33, 8'h01, 16'h0038,
      8'h06, 16'h0028, 64'h4444_00f8_0225_1111);
    cmp_frame();
    apb(1'b0, 8'h08, 32'h0);
    `CHK(rd, 32'h0002_0100)
  endtask
  // No digital field, all analog inputs, writes refused mid-frame.
  task automatic t_bare();
    int f0;
    slow <= 1'b0;
    apb(1'b1, 8'h14, 32'h0200_0001);
    apb(1'b1, 8'h18, 32'h00ff_8000);
    f0 = i_serial_host.good_q + i_serial_host.bad_q;
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b1, 8'h14, 32'h0);
    `CHK(er, 1'b1)
    apb(1'b1, 8'h04, 32'h1);
    wait_frame(f0);
    build(64'h1122_3344_5566_7788, 16'h0001, 8'h00, 8'h02, 16'h0000,
      8'h8f, 16'h0000, 64'h4444_00f8_0225_1111);
    cmp_frame();
    apb(1'b0, 8'h08, 32'h0);
    `CHK(rd, 32'h0003_0200)
  endtask
  // Reset, then the scenarios in turn.
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_refuse();
    t_sample();
    t_bare();
    test_done();
  end
endmodule
`default_nettype wire
